// ---- rtl/plc_timer_counter_unit.sv ----
// Scan-driven PLC timer and counter element
// Operation
// - On-delay: value from zero counts up while input on; output at preset; off clears.
// - Off-delay: input on loads preset, output on; off counts down, output off at zero.
// - Time base is 100 ms or 10 ms per count unit.
// - Integral timer keeps its value when input drops and resumes counting later.
// - Integral timer output turns on when value reaches preset.
// - Integral timer value is cleared only by explicit reset or by entry into run mode.
// - Monostable: like off-delay but input changes ignored while counting down.
// - Retrigger timer reloads preset on every input rising edge, even while counting.
// - Timing error stays within plus two and minus one scan.
// - Counters count once per input rising edge only.
// - Counter preset and value are 16-bit unsigned, max 65535.
// - Up counter output at preset; keeps counting, saturates at maximum.
// - Up counter reset clears value and output.
// - Down counter loads preset on entry into run mode.
// - Down counter decrements per rising edge; output on at zero.
// - Up-down counter: up edges increment, down edges decrement; an up and a down edge in the same scan leave the value unchanged.
// - Up-down counter output on while value at or above preset.
// - Ring counter counts to preset, output on, next edge clears both.
`include "plc_timer_counter_unit_params.svh"
`default_nettype none
module plc_timer_counter_unit
    import plc_timer_counter_pkg::*;
#(
    parameter int FAST_CYCLES = (`BASE_FAST_MS * `NS_PER_MS) / `CLK_PERIOD_NS
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire plc_timer_counter_pkg::func_t func_sel,
    input wire logic base_fast,
    input wire plc_timer_counter_pkg::value_t preset,
    input wire logic scan_strobe,
    input wire logic run_entry,
    input wire logic cond_in,
    input wire logic down_in,
    input wire logic reset_in,
    output plc_timer_counter_pkg::value_t current_value,
    output logic out_relay
);
    import plc_timer_counter_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Tick source and accumulation between scans
    tick_if ticks ();
    time_base_divider #(.FAST_CYCLES(FAST_CYCLES)) u_div (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .ticks(ticks)
    );

    value_t val_q, val_d;
    value_t pend_q, pend_d;
    logic out_q, out_d;
    logic cond_q, cond_d;
    logic down_q, down_d;
    logic tick;

    function automatic value_t sat_add(input value_t a, input value_t b);
        logic [16:0] s;
        s = {1'b0, a} + {1'b0, b};
        return s[16] ? `VALUE_MAX : s[15:0];
    endfunction

    function automatic value_t sat_sub(input value_t a, input value_t b);
        return (a > b) ? value_t'(a - b) : `VALUE_ZERO;
    endfunction

    assign tick = base_fast ? ticks.tick_fast : ticks.tick_slow;

    ////////////////////////////////////////////////////////////////////////
    // Scan evaluation
    // Inputs come from the scan engine on this clock, so no synchroniser.
    logic rise, fall, rise_dn;
    always_comb begin
        value_t el;
        el = `VALUE_ZERO;
        rise = cond_in && !cond_q;
        fall = !cond_in && cond_q;
        rise_dn = down_in && !down_q;
        val_d = val_q;
        out_d = out_q;
        cond_d = cond_q;
        down_d = down_q;
        // Ticks pile up so a long scan loses no time
        pend_d = tick ? sat_add(pend_q, `VALUE_ONE) : pend_q;
        if (scan_strobe) begin
            el = pend_d;
            pend_d = `VALUE_ZERO;
            cond_d = cond_in;
            down_d = down_in;
            unique case (func_sel)
                on_delay_timer: begin
                    if (cond_in) begin
                        val_d = cond_q ? sat_add(val_q, el) : `VALUE_ZERO;
                        out_d = (val_d >= preset);
                    end else begin
                        val_d = `VALUE_ZERO;
                        out_d = 1'b0;
                    end
                end
                integral_timer: begin
                    if (cond_in && cond_q) begin
                        val_d = sat_add(val_q, el);
                    end
                    out_d = (val_d >= preset);
                end
                off_delay_timer, monostable_timer, retrigger_timer: begin
                    if (func_sel == off_delay_timer && cond_in) begin
                        val_d = preset;
                        out_d = 1'b1;
                    end else if (func_sel == monostable_timer && rise && !out_q) begin
                        val_d = preset;
                        out_d = 1'b1;
                    end else if (func_sel == retrigger_timer && rise) begin
                        val_d = preset;
                        out_d = 1'b1;
                    end else if (out_q && (func_sel != off_delay_timer || !fall)) begin
                        // Countdown starts on the scan after the drop: error within +2/-1 scans
                        val_d = sat_sub(val_q, el);
                        out_d = (val_d != `VALUE_ZERO);
                    end
                end
                count_up_unit: begin
                    if (rise) begin
                        val_d = sat_add(val_q, `VALUE_ONE);
                    end
                    out_d = (val_d >= preset);
                end
                count_down_unit: begin
                    if (rise) begin
                        val_d = sat_sub(val_q, `VALUE_ONE);
                    end
                    out_d = (val_d == `VALUE_ZERO);
                end
                bidirectional_counter: begin
                    if (rise && !rise_dn) begin
                        val_d = sat_add(val_q, `VALUE_ONE);
                    end else if (rise_dn && !rise) begin
                        val_d = sat_sub(val_q, `VALUE_ONE);
                    end
                    out_d = (val_d >= preset);
                end
                wraparound_counter: begin
                    if (rise) begin
                        if (out_q) begin
                            val_d = `VALUE_ZERO;
                            out_d = 1'b0;
                        end else begin
                            val_d = sat_add(val_q, `VALUE_ONE);
                            out_d = (val_d >= preset);
                        end
                    end
                end
                default: begin
                    val_d = val_q;
                end
            endcase
            if (reset_in) begin
                // Down counter reset reloads preset; others clear
                val_d = (func_sel == count_down_unit) ? preset : `VALUE_ZERO;
                out_d = (func_sel == count_down_unit) && (preset == `VALUE_ZERO);
            end
        end
        if (run_entry) begin
            pend_d = `VALUE_ZERO;
            cond_d = 1'b0;
            down_d = 1'b0;
            val_d = (func_sel == count_down_unit) ? preset : `VALUE_ZERO;
            out_d = (func_sel == count_down_unit) && (preset == `VALUE_ZERO);
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            val_q <= `VALUE_ZERO;
            pend_q <= `VALUE_ZERO;
            out_q <= 1'b0;
            cond_q <= 1'b0;
            down_q <= 1'b0;
        end else begin
            val_q <= val_d;
            pend_q <= pend_d;
            out_q <= out_d;
            cond_q <= cond_d;
            down_q <= down_d;
        end
    end

    assign current_value = val_q;
    assign out_relay = out_q;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_scan_rise;
        scan_strobe && !run_entry && !reset_in && cond_in && !cond_q;
    endsequence

    AST_ON_CLEAR: assert property (@(posedge sys_clk) disable iff (!rstn)
        (scan_strobe && !cond_in && func_sel == on_delay_timer) |=> (val_q == 16'h0000 && !out_q))
        else $error("on-delay not cleared on input off");
    AST_OFF_LOAD: assert property (@(posedge sys_clk) disable iff (!rstn)
        (scan_strobe && !run_entry && !reset_in && cond_in && func_sel == off_delay_timer)
        |=> (val_q == $past(preset) && out_q))
        else $error("off-delay not loaded");
    AST_INT_KEEP: assert property (@(posedge sys_clk) disable iff (!rstn)
        (scan_strobe && !run_entry && !reset_in && !cond_in && func_sel == integral_timer)
        |=> $stable(val_q))
        else $error("integral value lost");
    AST_INT_OUT: assert property (@(posedge sys_clk) disable iff (!rstn)
        (func_sel == integral_timer && scan_strobe && !run_entry && !reset_in) |=> (out_q == (val_q >= $past(preset))))
        else $error("integral output wrong");
    AST_RETRIG: assert property (@(posedge sys_clk) disable iff (!rstn)
        (func_sel == retrigger_timer) and s_scan_rise |=> (val_q == $past(preset)))
        else $error("retrigger not reloaded");
    AST_UP_STEP: assert property (@(posedge sys_clk) disable iff (!rstn)
        (func_sel == count_up_unit && scan_strobe && !run_entry && !reset_in && !(cond_in && !cond_q))
        |=> $stable(val_q))
        else $error("counter moved without edge");
    AST_UP_RESET: assert property (@(posedge sys_clk) disable iff (!rstn)
        (func_sel == count_up_unit && scan_strobe && reset_in) |=> (val_q == 16'h0000 && !out_q))
        else $error("up counter not reset");
    AST_DOWN_RUN: assert property (@(posedge sys_clk) disable iff (!rstn)
        (func_sel == count_down_unit && run_entry) |=> (val_q == $past(preset)))
        else $error("down counter not loaded at run");
    AST_UD_OUT: assert property (@(posedge sys_clk) disable iff (!rstn)
        (func_sel == bidirectional_counter && scan_strobe && !run_entry && !reset_in)
        |=> (out_q == (val_q >= $past(preset))))
        else $error("up-down output wrong");
    AST_RING: assert property (@(posedge sys_clk) disable iff (!rstn)
        (func_sel == wraparound_counter && out_q) and s_scan_rise |=> (val_q == 16'h0000 && !out_q))
        else $error("ring counter not cleared");
endmodule
`default_nettype wire

// ---- rtl/plc_timer_counter_unit_params.svh ----
// Constants of the scan-driven timer and counter unit
`ifndef PLC_TIMER_COUNTER_UNIT_PARAMS_SVH
`define PLC_TIMER_COUNTER_UNIT_PARAMS_SVH
`define CLK_PERIOD_NS 10
`define BASE_SLOW_MS 100
`define BASE_FAST_MS 10
`define NS_PER_MS 1000000
`define VALUE_ZERO 16'h0000
`define VALUE_MAX 16'hFFFF
`define VALUE_ONE 16'h0001
`endif

// ---- rtl/plc_timer_counter_pkg.sv ----
// Types shared by the timer and counter unit
`default_nettype none
package plc_timer_counter_pkg;
    typedef enum logic [3:0] {
        on_delay_timer,
        off_delay_timer,
        integral_timer,
        monostable_timer,
        retrigger_timer,
        count_up_unit,
        count_down_unit,
        bidirectional_counter,
        wraparound_counter
    } func_t;
    typedef logic [15:0] value_t;
endpackage
`default_nettype wire

// ---- rtl/tick_if.sv ----
// Time-base tick carrier between the divider and the unit
`default_nettype none
interface tick_if;
    logic tick_fast;
    logic tick_slow;
    modport src (output tick_fast, output tick_slow);
    modport dst (input tick_fast, input tick_slow);
endinterface
`default_nettype wire

// ---- rtl/time_base_divider.sv ----
// Divider producing 10 ms and 100 ms tick enables
`include "plc_timer_counter_unit_params.svh"
`default_nettype none
module time_base_divider #(
    parameter int FAST_CYCLES = (`BASE_FAST_MS * `NS_PER_MS) / `CLK_PERIOD_NS,
    parameter int SLOW_DIV = `BASE_SLOW_MS / `BASE_FAST_MS
) (
    input wire logic sys_clk,
    input wire logic rstn,
    tick_if.src ticks
);
    logic [31:0] fast_cnt_q, fast_cnt_d;
    logic [7:0] slow_cnt_q, slow_cnt_d;
    logic fast_hit, slow_hit;

    // Refused at elaboration: the slow counter is only eight bits wide
    if (FAST_CYCLES < 1 || SLOW_DIV < 1 || SLOW_DIV > 255) begin
        $error("time_base_divider: bad divider parameters");
    end

    always_comb begin
        fast_hit = (fast_cnt_q == 32'(FAST_CYCLES - 1));
        slow_hit = fast_hit && (slow_cnt_q == 8'(SLOW_DIV - 1));
        fast_cnt_d = fast_hit ? 32'h0000_0000 : fast_cnt_q + 32'h0000_0001;
        slow_cnt_d = slow_cnt_q;
        if (fast_hit) begin
            slow_cnt_d = slow_hit ? 8'h00 : slow_cnt_q + 8'h01;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            fast_cnt_q <= 32'h0000_0000;
            slow_cnt_q <= 8'h00;
        end else begin
            fast_cnt_q <= fast_cnt_d;
            slow_cnt_q <= slow_cnt_d;
        end
    end

    assign ticks.tick_fast = fast_hit;
    assign ticks.tick_slow = slow_hit;
endmodule
`default_nettype wire

// ---- sim/scan_engine_model.sv ----
// Scan engine model issuing one strobe per scan of the user program
`default_nettype none
module scan_engine_model #(
    parameter int SCAN_CYCLES = 20
) (
    input wire logic sys_clk,
    input wire logic rstn,
    output logic scan_strobe
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt_q;
    ////////////////////////////////////////////////////////////////
    // A fixed scan period lets every input level span a whole scan
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cnt_q <= 0;
            scan_strobe <= 1'b0;
        end else begin
            cnt_q <= (cnt_q == SCAN_CYCLES - 1) ? 0 : cnt_q + 1;
            scan_strobe <= (cnt_q == SCAN_CYCLES - 1);
        end
    end
endmodule
`default_nettype wire

// ---- sim/plc_timer_counter_unit_tb_top.sv ----
// Self-checking bench for the timer and counter unit
`default_nettype none
module plc_timer_counter_unit_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import plc_timer_counter_pkg::*;
    typedef struct {func_t f; value_t p; int op; logic c; logic d; logic [1:0] m; value_t v; logic q;} row_t;
    localparam func_t f_up = count_up_unit;
    localparam func_t f_dn = count_down_unit;
    localparam func_t f_ud = bidirectional_counter;
    localparam func_t f_rg = wraparound_counter;
    localparam func_t f_on = on_delay_timer;
    localparam func_t f_of = off_delay_timer;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic base_fast = 1'b1;
    logic run_entry = 1'b0;
    logic cond_in = 1'b0;
    logic down_in = 1'b0;
    logic reset_in = 1'b0;
    logic scan_strobe;
    logic out_relay;
    func_t func_sel = count_up_unit;
    value_t preset = 16'h0000;
    value_t current_value;
    value_t held;
    int fails = 0;
    int checked = 0;
    int cyc = 0;
    // op 1 enters run mode, op 2 scans with reset_in; m bit1 checks value, bit0 relay
    row_t rows [0:38] = '{
        '{f_up,2,1,0,0,3,0,0}, '{f_up,2,0,1,0,3,1,0}, '{f_up,2,0,1,0,3,1,0}, '{f_up,2,0,0,0,3,1,0},
        '{f_up,2,0,1,0,3,2,1}, '{f_up,2,0,0,0,3,2,1}, '{f_up,2,0,1,0,3,3,1}, '{f_up,2,2,0,0,3,0,0},
        '{f_dn,2,1,0,0,3,2,0}, '{f_dn,2,0,1,0,3,1,0}, '{f_dn,2,0,0,0,3,1,0}, '{f_dn,2,0,1,0,3,0,1},
        '{f_dn,2,0,0,0,3,0,1}, '{f_dn,2,2,0,0,3,2,0},
        '{f_ud,1,1,0,0,3,0,0}, '{f_ud,1,0,1,0,3,1,1}, '{f_ud,1,0,0,1,3,0,0}, '{f_ud,1,0,1,0,3,1,1},
        '{f_ud,1,0,0,0,3,1,1}, '{f_ud,1,0,1,1,3,1,1},
        '{f_rg,2,1,0,0,3,0,0}, '{f_rg,2,0,1,0,3,1,0}, '{f_rg,2,0,0,0,3,1,0}, '{f_rg,2,0,1,0,3,2,1},
        '{f_rg,2,0,0,0,3,2,1}, '{f_rg,2,0,1,0,3,0,0},
        '{f_on,3,1,0,0,3,0,0}, '{f_on,3,0,1,0,3,0,0}, '{f_on,3,0,1,0,0,0,0}, '{f_on,3,0,1,0,0,0,0},
        '{f_on,3,0,1,0,1,0,1}, '{f_on,3,0,0,0,3,0,0},
        '{f_of,3,1,0,0,3,0,0}, '{f_of,3,0,1,0,3,3,1}, '{f_of,3,0,0,0,3,3,1}, '{f_of,3,0,0,0,0,0,0},
        '{f_of,3,0,0,0,0,0,0}, '{f_of,3,0,0,0,0,0,0}, '{f_of,3,0,0,0,3,0,0}
    };

    always #5 sys_clk = ~sys_clk;

    plc_timer_counter_unit #(.FAST_CYCLES(10)) u_dut (.sys_clk(sys_clk), .rstn(rstn), .func_sel(func_sel),
        .base_fast(base_fast), .preset(preset), .scan_strobe(scan_strobe), .run_entry(run_entry),
        .cond_in(cond_in), .down_in(down_in), .reset_in(reset_in), .current_value(current_value),
        .out_relay(out_relay));

    scan_engine_model #(.SCAN_CYCLES(20)) u_scan (.sys_clk(sys_clk), .rstn(rstn), .scan_strobe(scan_strobe));

    ////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        $display("checks=%0d mismatches=%0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic miss(input value_t got, input value_t exp);
        fails++;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    endtask

    task automatic chk(input value_t v, input logic q, input logic [1:0] m);
        if (m[1]) begin
            checked++;
            if (current_value !== v) miss(current_value, v);
        end
        if (m[0]) begin
            checked++;
            if (out_relay !== q) miss({15'h0000, out_relay}, {15'h0000, q});
        end
    endtask

    // Levels change once per scan; result read on the second falling edge after the strobe
    task automatic step(input logic c, input logic d, input logic r);
        @(negedge sys_clk);
        cond_in = c;
        down_in = d;
        reset_in = r;
        @(posedge sys_clk);
        while (scan_strobe !== 1'b1) begin
            @(posedge sys_clk);
        end
        repeat (2) @(negedge sys_clk);
    endtask

    // Function changes only together with the run-mode entry pulse
    task automatic enter(input func_t f, input value_t p);
        @(negedge sys_clk);
        func_sel = f;
        preset = p;
        cond_in = 1'b0;
        down_in = 1'b0;
        reset_in = 1'b0;
        run_entry = 1'b1;
        @(negedge sys_clk);
        run_entry = 1'b0;
        @(negedge sys_clk);
    endtask

    ////////////////////////////////////////////////////////////////
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 8000) begin
            fails++;
            report_and_stop();
        end
    end

    initial begin
        repeat (8) @(negedge sys_clk);
        chk(16'h0000, 1'b0, 2'd3);
        rstn = 1'b1;
        $display("test reset done");
        foreach (rows[i]) begin
            if (rows[i].op == 1) enter(rows[i].f, rows[i].p);
            else step(rows[i].c, rows[i].d, rows[i].op == 2);
            chk(rows[i].v, rows[i].q, rows[i].m);
        end
        $display("test table done");
        enter(integral_timer, 16'h0008);
        repeat (3) step(1'b1, 1'b0, 1'b0);
        repeat (2) step(1'b0, 1'b0, 1'b0);
        held = current_value;
        step(1'b0, 1'b0, 1'b0);
        chk(held, 1'b0, 2'd3);
        if (held === 16'h0000) miss(held, 16'h0001);
        repeat (6) step(1'b1, 1'b0, 1'b0);
        chk(held, 1'b1, 2'd1);
        step(1'b0, 1'b0, 1'b1);
        chk(16'h0000, 1'b0, 2'd3);
        $display("test integral done");
        base_fast = 1'b0;
        enter(on_delay_timer, 16'h0002);
        repeat (3) step(1'b1, 1'b0, 1'b0);
        chk(16'h0000, 1'b0, 2'd1);
        repeat (12) step(1'b1, 1'b0, 1'b0);
        chk(16'h0000, 1'b1, 2'd1);
        base_fast = 1'b1;
        $display("test slow base done");
        for (int k = 0; k < 2; k++) begin
            enter(k == 0 ? retrigger_timer : monostable_timer, 16'h0008);
            step(1'b1, 1'b0, 1'b0);
            repeat (2) step(1'b0, 1'b0, 1'b0);
            step(1'b1, 1'b0, 1'b0);
            if (k == 0) chk(16'h0008, 1'b1, 2'd3);
            else begin
                checked++;
                // Ignored edge: the countdown carries on below the preset
                if ((current_value < 16'h0008) !== 1'b1 || out_relay !== 1'b1) miss(current_value, 16'h0008);
            end
        end
        $display("test retrigger done");
        enter(count_up_unit, 16'h0001);
        step(1'b1, 1'b0, 1'b0);
        @(negedge sys_clk);
        rstn = 1'b0;
        #1;
        chk(16'h0000, 1'b0, 2'd3);
        repeat (2) @(negedge sys_clk);
        rstn = 1'b1;
        step(1'b0, 1'b0, 1'b0);
        enter(count_up_unit, 16'h0001);
        step(1'b1, 1'b0, 1'b0);
        chk(16'h0001, 1'b1, 2'd3);
        $display("test async reset done");
        report_and_stop();
    end
endmodule
`default_nettype wire
